// ==== rtl/etsa_top.sv ====
// Notes on behaviour
// - Eight-bit up-counter with separate preload register holding the reload value.
// - Two control bits pick main clock, slow clock, pin, or main AND pin.
// - Writing the counter stores nothing; it copies the preload into the counter.
// - Preload is a buffer, writable right after a load, count undisturbed.
// - Software reads and writes the preload register with ordinary accesses.
// - With enable high count up on each selected clock edge, except at CNT_MAX while the receive buffer is full; else hold.
// - With start-bit detection on, counter waits for the start edge, then counts.
// - After the first interval following the start edge, sample receive input.
// - Receive and transmit latches are clocked by counter carry-out.
// - Transmit stream leaves bit by bit, timed by interval, bits from software.
// - Timer input and serial data pins are shared with general port logic.
//
// The AXI4-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
module etsa_top
    import etsa_pkg::*;
(
    // Clock and reset
    input  wire logic                       CLK_SYS,
    input  wire logic                       RST,
    // AXI4-Lite write address
    input  wire logic [etsa_pkg::ADDR_W-1:0] AWADDR,
    input  wire logic                       AWVALID,
    output logic                            AWREADY,
    // AXI4-Lite write data
    input  wire logic [etsa_pkg::DATA_W-1:0] WDATA,
    input  wire logic [3:0]                 WSTRB,
    input  wire logic                       WVALID,
    output logic                            WREADY,
    // AXI4-Lite write response
    output logic      [1:0]                 BRESP,
    output logic                            BVALID,
    input  wire logic                       BREADY,
    // AXI4-Lite read address
    input  wire logic [etsa_pkg::ADDR_W-1:0] ARADDR,
    input  wire logic                       ARVALID,
    output logic                            ARREADY,
    // AXI4-Lite read data
    output logic      [etsa_pkg::DATA_W-1:0] RDATA,
    output logic      [1:0]                 RRESP,
    output logic                            RVALID,
    input  wire logic                       RREADY,
    // Shared port pins
    input  wire logic                       TIMER_EXTERNAL_INPUT_PIN,
    input  wire logic                       SER_RX_IN,
    output logic                            SER_TX_OUT,
    output logic                            SER_TX_OE,
    // General port logic on the shared serial pin
    input  wire logic                       PORT_TX_OUT,
    input  wire logic                       PORT_TX_OE,
    // Counter carry-out
    output logic                            CARRY_OUT
);
    import etsa_pkg::*;

    // -------------------------------------------------------------
    // State
    // -------------------------------------------------------------
    logic [5:0]        ctl_q, ctl_d;
    logic [7:0]        pld_q, pld_d;
    logic [7:0]        cnt_q, cnt_d;
    logic              receive_sample_latch_q, receive_sample_latch_d;
    logic              transmit_output_latch_q, transmit_output_latch_d;
    logic              carry_q, carry_d;
    logic              tin_prev_q, rx_prev_q;
    logic [3:0]        aclk_cnt_q, aclk_cnt_d;
    logic              aclk_en;
    etsa_state_t       state_q, state_d;
    logic              tx_out_q, tx_out_d, tx_oe_q, tx_oe_d;

    logic              aw_have_q, aw_have_d, w_have_q, w_have_d;
    logic [ADDR_W-1:0] aw_addr_q, aw_addr_d;
    logic [7:0]        w_data_q, w_data_d;
    logic              w_lane_q, w_lane_d;
    logic              awready_q, awready_d, wready_q, wready_d;
    logic              bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
    logic [1:0]        bresp_q, bresp_d, rresp_q, rresp_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;

    logic              wr_fire, wr_ok, cnt_load, pld_load, rd_fire;
    logic              tick, run, wrap, stall;
    logic              rxq_in_ready, rxq_out_valid, rxq_pop;
    logic              rxq_out_data;

    // -------------------------------------------------------------
    // Address decode
    // -------------------------------------------------------------
    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        mapped = (a == etsa_addr(IDX_CTL)) || (a == etsa_addr(IDX_PLD)) ||
                 (a == etsa_addr(IDX_DAT)) || (a == etsa_addr(IDX_RXB));
    endfunction

    // -------------------------------------------------------------
    // Slow clock enable
    // -------------------------------------------------------------
    always_comb begin
        aclk_en    = (aclk_cnt_q == ACLK_DIV);
        aclk_cnt_d = aclk_en ? '0 : aclk_cnt_q + ACLK_ONE;
    end

    // -------------------------------------------------------------
    // AXI4-Lite write channel
    // -------------------------------------------------------------
    always_comb begin
        aw_have_d = aw_have_q;
        aw_addr_d = aw_addr_q;
        w_have_d  = w_have_q;
        w_data_d  = w_data_q;
        w_lane_d  = w_lane_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        if (AWVALID && awready_q) begin
            aw_have_d = 1'b1;
            aw_addr_d = AWADDR;
        end
        if (WVALID && wready_q) begin
            w_have_d = 1'b1;
            w_data_d = WDATA[7:0];
            w_lane_d = WSTRB[0];
        end
        if (bvalid_q && BREADY) begin
            bvalid_d = 1'b0;
        end
        wr_fire = aw_have_q && w_have_q && !bvalid_q;
        wr_ok   = wr_fire && mapped(aw_addr_q) && w_lane_q;
        if (wr_fire) begin
            aw_have_d = 1'b0;
            w_have_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
        end
        awready_d = !aw_have_d && !bvalid_d;
        wready_d  = !w_have_d && !bvalid_d;
    end

    // -------------------------------------------------------------
    // Register writes
    // -------------------------------------------------------------
    always_comb begin
        ctl_d    = ctl_q;
        pld_d    = pld_q;
        cnt_load = wr_ok && (aw_addr_q == etsa_addr(IDX_DAT));
        pld_load = wr_ok && (aw_addr_q == etsa_addr(IDX_PLD));
        if (wr_ok && (aw_addr_q == etsa_addr(IDX_CTL))) begin
            ctl_d = w_data_q[5:0];
        end
        if (pld_load) begin
            pld_d = w_data_q;
        end
    end

    // -------------------------------------------------------------
    // AXI4-Lite read channel
    // -------------------------------------------------------------
    always_comb begin
        rvalid_d = rvalid_q;
        rresp_d  = rresp_q;
        rdata_d  = rdata_q;
        rxq_pop  = 1'b0;
        rd_fire  = ARVALID && arready_q;
        if (rvalid_q && RREADY) begin
            rvalid_d = 1'b0;
        end
        if (rd_fire) begin
            rvalid_d = 1'b1;
            rresp_d  = mapped(ARADDR) ? RESP_OKAY : RESP_SLVERR;
            rdata_d  = '0;
            case (ARADDR)
                etsa_addr(IDX_CTL): begin
                    rdata_d[5:0]         = ctl_q;
                    rdata_d[CTL_RXLATCH] = receive_sample_latch_q;
                    rdata_d[CTL_TXLATCH] = transmit_output_latch_q;
                end
                etsa_addr(IDX_PLD): begin
                    rdata_d[7:0] = pld_q;
                end
                etsa_addr(IDX_DAT): begin
                    rdata_d[7:0] = cnt_q;
                end
                etsa_addr(IDX_RXB): begin
                    rdata_d[RXB_VALID] = rxq_out_valid;
                    rdata_d[0]         = rxq_out_valid & rxq_out_data;
                    rxq_pop            = rxq_out_valid;
                end
                default: begin
                    rdata_d = '0;
                end
            endcase
        end
        arready_d = !rvalid_d;
    end

    // -------------------------------------------------------------
    // Clock source select and start-bit detection
    // -------------------------------------------------------------
    always_comb begin
        case (etsa_src_t'(ctl_q[CTL_SSEL_LSB +: 2]))
            SRC_MCLK: tick = 1'b1;
            SRC_ACLK: tick = aclk_en;
            SRC_PIN:  tick = TIMER_EXTERNAL_INPUT_PIN && !tin_prev_q;
            SRC_AND:  tick = TIMER_EXTERNAL_INPUT_PIN;
            default:  tick = 1'b0;
        endcase
        state_d = state_q;
        case (state_q)
            ST_WAIT: begin
                if (ctl_q[CTL_STDET] && rx_prev_q && !SER_RX_IN) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!ctl_q[CTL_STDET]) begin
                    state_d = ST_WAIT;
                end
            end
            default: begin
                state_d = ST_WAIT;
            end
        endcase
        run = ctl_q[CTL_EN] && (!ctl_q[CTL_STDET] || state_q == ST_RUN);
    end

    // -------------------------------------------------------------
    // Counter, carry and data latches
    // -------------------------------------------------------------
    always_comb begin
        cnt_d                   = cnt_q;
        carry_d                 = 1'b0;
        receive_sample_latch_d  = receive_sample_latch_q;
        transmit_output_latch_d = transmit_output_latch_q;
        wrap                    = (cnt_q == CNT_MAX);
        stall                   = wrap && !rxq_in_ready;
        if (cnt_load) begin
            cnt_d = pld_q;
        end else if (run && tick && !stall) begin
            cnt_d = wrap ? CNT_RST : cnt_q + CNT_ONE;
            if (wrap) begin
                carry_d                 = 1'b1;
                receive_sample_latch_d  = SER_RX_IN;
                transmit_output_latch_d = ctl_q[CTL_TXBIT];
            end
        end
    end

    // -------------------------------------------------------------
    // Shared serial pin
    // -------------------------------------------------------------
    always_comb begin
        if (ctl_q[CTL_PORTSEL]) begin
            tx_out_d = transmit_output_latch_d;
            tx_oe_d  = 1'b1;
        end else begin
            tx_out_d = PORT_TX_OUT;
            tx_oe_d  = PORT_TX_OE;
        end
    end

    // -------------------------------------------------------------
    // Receive sample buffer
    // -------------------------------------------------------------
    etsa_fifo2 #(
        .WIDTH (1),
        .DEPTH (RXQ_DEPTH)
    ) u_rxq (
        .clk       (CLK_SYS),
        .rst       (RST),
        .in_valid  (carry_d),
        .in_ready  (rxq_in_ready),
        .in_data   (receive_sample_latch_d),
        .out_valid (rxq_out_valid),
        .out_ready (rxq_pop),
        .out_data  (rxq_out_data)
    );

    // -------------------------------------------------------------
    // Registers
    // -------------------------------------------------------------
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            ctl_q                   <= CTL_RST;
            pld_q                   <= PLD_RST;
            cnt_q                   <= CNT_RST;
            carry_q                 <= 1'b0;
            receive_sample_latch_q  <= 1'b0;
            transmit_output_latch_q <= TX_IDLE;
            tin_prev_q              <= 1'b0;
            rx_prev_q               <= 1'b1;
            aclk_cnt_q              <= '0;
            state_q                 <= ST_WAIT;
            tx_out_q                <= 1'b0;
            tx_oe_q                 <= 1'b0;
            aw_have_q               <= 1'b0;
            aw_addr_q               <= '0;
            w_have_q                <= 1'b0;
            w_data_q                <= '0;
            w_lane_q                <= 1'b0;
            awready_q               <= 1'b0;
            wready_q                <= 1'b0;
            bvalid_q                <= 1'b0;
            bresp_q                 <= RESP_OKAY;
            arready_q               <= 1'b0;
            rvalid_q                <= 1'b0;
            rresp_q                 <= RESP_OKAY;
            rdata_q                 <= '0;
        end else begin
            ctl_q                   <= ctl_d;
            pld_q                   <= pld_d;
            cnt_q                   <= cnt_d;
            carry_q                 <= carry_d;
            receive_sample_latch_q  <= receive_sample_latch_d;
            transmit_output_latch_q <= transmit_output_latch_d;
            tin_prev_q              <= TIMER_EXTERNAL_INPUT_PIN;
            rx_prev_q               <= SER_RX_IN;
            aclk_cnt_q              <= aclk_cnt_d;
            state_q                 <= state_d;
            tx_out_q                <= tx_out_d;
            tx_oe_q                 <= tx_oe_d;
            aw_have_q               <= aw_have_d;
            aw_addr_q               <= aw_addr_d;
            w_have_q                <= w_have_d;
            w_data_q                <= w_data_d;
            w_lane_q                <= w_lane_d;
            awready_q               <= awready_d;
            wready_q                <= wready_d;
            bvalid_q                <= bvalid_d;
            bresp_q                 <= bresp_d;
            arready_q               <= arready_d;
            rvalid_q                <= rvalid_d;
            rresp_q                 <= rresp_d;
            rdata_q                 <= rdata_d;
        end
    end

    // -------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------
    assign AWREADY    = awready_q;
    assign WREADY     = wready_q;
    assign BVALID     = bvalid_q;
    assign BRESP      = bresp_q;
    assign ARREADY    = arready_q;
    assign RVALID     = rvalid_q;
    assign RRESP      = rresp_q;
    assign RDATA      = rdata_q;
    assign SER_TX_OUT = tx_out_q;
    assign SER_TX_OE  = tx_oe_q;
    assign CARRY_OUT  = carry_q;

endmodule

// ==== rtl/etsa_pkg.sv ====
package etsa_pkg;

    // -------------------------------------------------------------
    // Bus geometry
    // -------------------------------------------------------------
    localparam int          ADDR_W       = 12;
    localparam int          DATA_W       = 32;
    localparam int          CNT_W        = 8;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    // -------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // -------------------------------------------------------------
    localparam logic [7:0]  IDX_CTL      = 8'h42;
    localparam logic [7:0]  IDX_PLD      = 8'h43;
    localparam logic [7:0]  IDX_DAT      = 8'h44;
    localparam logic [7:0]  IDX_RXB      = 8'h45;

    // -------------------------------------------------------------
    // Control and receive buffer register fields
    // -------------------------------------------------------------
    localparam int          CTL_SSEL_LSB = 0;
    localparam int          CTL_EN       = 2;
    localparam int          CTL_STDET    = 3;
    localparam int          CTL_TXBIT    = 4;
    localparam int          CTL_PORTSEL  = 5;
    localparam int          CTL_RXLATCH  = 6;
    localparam int          CTL_TXLATCH  = 7;
    localparam logic [5:0]  CTL_RST      = 6'h00;
    localparam int          RXB_VALID    = 7;

    // -------------------------------------------------------------
    // Reset values and timing
    // -------------------------------------------------------------
    localparam logic [7:0]  CNT_RST      = 8'h00;
    localparam logic [7:0]  CNT_MAX      = 8'hFF;
    localparam logic [7:0]  CNT_ONE      = 8'h01;
    localparam logic [7:0]  PLD_RST      = 8'h00;
    localparam logic        TX_IDLE      = 1'b1;
    localparam logic [3:0]  ACLK_DIV     = 4'hF;
    localparam logic [3:0]  ACLK_ONE     = 4'h1;
    localparam int          RXQ_DEPTH    = 2;

    // -------------------------------------------------------------
    // Types
    // -------------------------------------------------------------
    typedef enum logic [1:0] {
        SRC_MCLK = 2'b00,
        SRC_ACLK = 2'b01,
        SRC_PIN  = 2'b10,
        SRC_AND  = 2'b11
    } etsa_src_t;

    typedef enum logic {
        ST_WAIT = 1'b0,
        ST_RUN  = 1'b1
    } etsa_state_t;

    function automatic logic [ADDR_W-1:0] etsa_addr(input logic [7:0] idx);
        etsa_addr = {2'h0, idx, 2'h0};
    endfunction

endpackage

// ==== rtl/etsa_fifo2.sv ====
`timescale 1ns/1ps
module etsa_fifo2 #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PW:0]   LAST  = (PW + 1)'(DEPTH - 1);
    localparam logic [PW:0]   FULLC = (PW + 1)'(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0]    wr_q, wr_d, rd_q, rd_d;
    logic [PW:0]      cnt_q, cnt_d;
    logic             push, pop;

    // -------------------------------------------------------------
    // Pointer and count update
    // -------------------------------------------------------------
    always_comb begin
        push  = in_valid && in_ready;
        pop   = out_valid && out_ready;
        wr_d  = wr_q;
        rd_d  = rd_q;
        cnt_d = cnt_q;
        if (push) begin
            wr_d = ({1'b0, wr_q} == LAST) ? '0 : wr_q + 1'b1;
        end
        if (pop) begin
            rd_d = ({1'b0, rd_q} == LAST) ? '0 : rd_q + 1'b1;
        end
        if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    assign in_ready  = (cnt_q != FULLC);
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];

endmodule

// ==== tb/etsa_checker.sv ====
`timescale 1ns/1ps
module etsa_checker (
    // Clock and reset
    input wire logic                         CLK_SYS,
    input wire logic                         RST,
    // Write channels
    input wire logic                         AWVALID,
    input wire logic                         AWREADY,
    input wire logic                         WVALID,
    input wire logic                         WREADY,
    input wire logic [1:0]                   BRESP,
    input wire logic                         BVALID,
    input wire logic                         BREADY,
    // Read channels
    input wire logic [etsa_pkg::ADDR_W-1:0]  ARADDR,
    input wire logic                         ARVALID,
    input wire logic                         ARREADY,
    input wire logic [etsa_pkg::DATA_W-1:0]  RDATA,
    input wire logic [1:0]                   RRESP,
    input wire logic                         RVALID,
    input wire logic                         RREADY,
    // Serial side
    input wire logic                         SER_TX_OE,
    input wire logic                         CARRY_OUT
);
    import etsa_pkg::*;
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    chk_write_answer: assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##2 BVALID)
        else $error("write response not on time");
    chk_bresp_hold: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
        else $error("write response dropped early");
    chk_write_block: assert property (BVALID |-> !AWREADY && !WREADY)
        else $error("write taken while response pending");
    chk_read_answer: assert property (ARVALID && ARREADY |=> RVALID)
        else $error("read data not on time");
    chk_rdata_hold: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA) && $stable(RRESP))
        else $error("read data changed while waiting");
    chk_unmapped_read: assert property (ARVALID && ARREADY && (ARADDR[11:2] < {2'h0, IDX_CTL}
        || ARADDR[11:2] > {2'h0, IDX_RXB}) |=> RRESP == RESP_SLVERR && RDATA == 32'h0)
        else $error("unmapped read not refused");
    chk_rdata_width: assert property (RVALID |-> RDATA[31:8] == 24'h0)
        else $error("read data wider than eight bits");
    chk_carry_pulse: assert property (CARRY_OUT |=> !CARRY_OUT [*2])
        else $error("carry out longer than one cycle");
    chk_reset_quiet: assert property (disable iff (1'b0) RST |-> !BVALID && !RVALID && !CARRY_OUT && !SER_TX_OE)
        else $error("outputs active during reset");
endmodule

bind etsa_top etsa_checker i_chk (.CLK_SYS(CLK_SYS), .RST(RST), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
    .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
    .SER_TX_OE(SER_TX_OE), .CARRY_OUT(CARRY_OUT));

// ==== tb/etsa_ser_model.sv ====
`timescale 1ns/1ps
module etsa_ser_model #(
    parameter int BIT_CYC = 16
) (
    // Clock and frame request
    input wire logic       clk,
    input wire logic       go,
    input wire logic [7:0] data,
    // Serial line toward the timer
    output logic           rx
);
    int         cnt = 0;
    int         idx = 10;
    logic [9:0] frame = 10'h3FF;
    initial rx = 1'b1;
    always @(posedge clk) begin
        if (go && idx == 10) begin
            frame <= {1'b1, data, 1'b0};
            idx <= 0;
            cnt <= 0;
            rx <= 1'b0;
        end else if (idx < 10) begin
            if (cnt == BIT_CYC - 1) begin
                cnt <= 0;
                idx <= idx + 1;
                rx <= (idx == 9) ? 1'b1 : frame[idx+1];
            end else begin
                cnt <= cnt + 1;
            end
        end
    end
endmodule

// ==== tb/etsa_top_tb.sv ====
`timescale 1ns/1ps
module etsa_top_tb;
    import etsa_pkg::*;
    logic        CLK_SYS = 1'b0;
    logic        RST = 1'b0;
    logic [11:0] AWADDR = 12'h000;
    logic [11:0] ARADDR = 12'h000;
    logic [31:0] WDATA = 32'h0;
    logic        AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
    logic        pin = 0, ptx = 0, poe = 0, go = 0;
    logic [7:0]  sdat = 8'h01;
    logic [7:0]  v;
    logic [1:0]  BRESP, RRESP;
    logic [31:0] RDATA;
    logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, rx, txo, txoe, co;
    logic [33:0] exp_q[$];
    int          error_cnt = 0, compares = 0, cyc = 0, ncar = 0, n, ex;

    always #12.5 CLK_SYS = ~CLK_SYS;

    etsa_top i_dut (.CLK_SYS(CLK_SYS), .RST(RST), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
        .WDATA(WDATA), .WSTRB(4'hF), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
        .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
        .RVALID(RVALID), .RREADY(RREADY), .TIMER_EXTERNAL_INPUT_PIN(pin), .SER_RX_IN(rx), .SER_TX_OUT(txo),
        .SER_TX_OE(txoe), .PORT_TX_OUT(ptx), .PORT_TX_OE(poe), .CARRY_OUT(co));
    etsa_ser_model #(.BIT_CYC(20)) i_ser (.clk(CLK_SYS), .go(go), .data(sdat), .rx(rx));

    task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] e);
        compares++;
        if (seen !== e) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", nm, e, seen);
        end
    endtask

    task automatic summarize();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] e = RESP_OKAY);
        exp_q.push_back({e, 32'h0});
        AWADDR <= {2'h0, idx, 2'h0};
        WDATA <= {24'h0, d};
        AWVALID <= 1;
        WVALID <= 1;
        do begin
            @(posedge CLK_SYS);
            AWVALID <= AWVALID && !AWREADY;
            WVALID <= WVALID && !WREADY;
        end while ((AWVALID && !AWREADY) || (WVALID && !WREADY));
        BREADY <= 1;
        do @(posedge CLK_SYS); while (BVALID !== 1'b1);
        BREADY <= 0;
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] e, input logic [1:0] r = RESP_OKAY);
        exp_q.push_back({r, 24'h0, e});
        ARADDR <= {2'h0, idx, 2'h0};
        ARVALID <= 1;
        do @(posedge CLK_SYS); while (ARREADY !== 1'b1);
        ARVALID <= 0;
        RREADY <= 1;
        do @(posedge CLK_SYS); while (RVALID !== 1'b1);
        RREADY <= 0;
    endtask

    task automatic wait_carry(output int k);
        k = 0;
        do begin
            @(posedge CLK_SYS);
            k++;
        end while (co !== 1'b1 && k < 400);
    endtask

    always @(posedge CLK_SYS) begin
        cyc++;
        pin <= cyc[1];
        if (co === 1'b1) ncar++;
        if (BVALID === 1'b1 && BREADY) chk("bresp", {BRESP, 32'h0}, exp_q.pop_front());
        if (RVALID === 1'b1 && RREADY) chk("rdata", {RRESP, RDATA}, exp_q.pop_front());
        if (cyc == 20000) begin
            error_cnt++;
            summarize();
        end
    end

    initial begin
        RST <= 1'b1;
        void'($urandom(32'h3ebe));
        repeat (4) @(posedge CLK_SYS);
        RST <= 0;
        @(posedge CLK_SYS);
        v = $urandom();
        for (int i = 0; i < 2; i++) begin
            ptx <= v[0] ^ i[0];
            poe <= 1;
            repeat (3) @(posedge CLK_SYS);
            chk("port_pin", {32'h0, txoe, txo}, {32'h0, 1'b1, ptx});
        end
        rd(IDX_CTL, 8'h80);
        rd(IDX_DAT, 8'h00);
        rd(8'h50, 8'h00, RESP_SLVERR);
        wr(8'h50, 8'hAA, RESP_SLVERR);
        wr(IDX_PLD, v);
        rd(IDX_PLD, v);
        rd(IDX_DAT, 8'h00);
        wr(IDX_DAT, ~v);
        repeat (10) @(posedge CLK_SYS);
        rd(IDX_DAT, v);
        wr(IDX_PLD, 8'hF0);
        for (int s = 0; s < 4; s++) begin
            wr(IDX_DAT, 8'h00);
            wr(IDX_CTL, 8'(s));
            n = ncar;
            repeat (30) @(posedge CLK_SYS);
            chk("hold", 34'(ncar), 34'(n));
            wr(IDX_CTL, 8'(4 + s));
            wait_carry(n);
            ex = (s == 0) ? 16 : (s == 1) ? 256 : (s == 2) ? 64 : 32;
            chk("interval", 34'(n >= ex - ex / 16 - 2 && n <= ex + 2), 34'h1);
            wr(IDX_CTL, 8'h00);
            rd(IDX_RXB, 8'h81);
        end
        wr(IDX_PLD, 8'hF6);
        wr(IDX_DAT, 8'h00);
        wr(IDX_PLD, 8'hF0);
        wr(IDX_CTL, 8'h0C);
        n = ncar;
        repeat (40) @(posedge CLK_SYS);
        chk("idle", 34'(ncar), 34'(n));
        sdat <= 8'($urandom()) | 8'h01;
        go <= 1;
        @(posedge CLK_SYS);
        go <= 0;
        wait_carry(n);
        wr(IDX_DAT, 8'h00);
        wait_carry(n);
        rd(IDX_RXB, 8'h80);
        rd(IDX_RXB, 8'h81);
        rd(IDX_RXB, 8'h00);
        wr(IDX_CTL, 8'h00);
        repeat (200) @(posedge CLK_SYS);
        for (int b = 0; b < 2; b++) begin
            wr(IDX_DAT, 8'h00);
            wr(IDX_CTL, 8'(8'h24 | (b << 4)));
            wait_carry(n);
            chk("tx_pin", {32'h0, txoe, txo}, {32'h0, 1'b1, b[0]});
            rd(IDX_CTL, {b[0], 1'b1, 6'(6'h24 | (b << 4))});
            rd(IDX_RXB, 8'h81);
        end
        wr(IDX_CTL, 8'h00);
        summarize();
    end
endmodule
